// ---- design/lpmcs_defs.vh ----
// constants for the low-power mode and clock switch controller
`ifndef LPMCS_DEFS_VH
`define LPMCS_DEFS_VH

// ----------------------------------------------------------------------
// power state codes (one-hot)
// ----------------------------------------------------------------------
`define LPMCS_P_RUN 3'h1
`define LPMCS_P_HALT 3'h2
`define LPMCS_P_WARM 3'h4

// ----------------------------------------------------------------------
// clock switch state codes (one-hot)
// ----------------------------------------------------------------------
`define LPMCS_C_FAST 4'h1
`define LPMCS_C_TO_LOW 4'h2
`define LPMCS_C_LOW 4'h4
`define LPMCS_C_TO_FAST 4'h8

// ----------------------------------------------------------------------
// operating mode codes shown on mode_out
// ----------------------------------------------------------------------
`define LPMCS_MODE_SINGLE 3'h0
`define LPMCS_MODE_DUAL 3'h1
`define LPMCS_MODE_LOW 3'h2
`define LPMCS_MODE_IDLE 3'h3
`define LPMCS_MODE_SLEEP 3'h4
`define LPMCS_MODE_WARM 3'h5

// ----------------------------------------------------------------------
// timing counts, in periods of the clock named
// ----------------------------------------------------------------------
// gear periods before the stop when going to low speed
`define LPMCS_TO_LOW_GEAR 4'h2
// low-frequency periods, most, that the main clock stands going low
`define LPMCS_TO_LOW_LF 4'hA
// low-frequency periods, most, before the stop when going fast
`define LPMCS_TO_FAST_LF 4'h8
// gear periods of stop going fast: 2.5 rounded down
`define LPMCS_TO_FAST_GEAR 4'h2
// machine cycles after a select change that guard the enables
`define LPMCS_WIN_MC 2'h2
// low-frequency divider phase that marks a quarter-rate edge
`define LPMCS_LF_LAST 2'h3
// program counter step held while halted
`define LPMCS_PC_STEP 16'h0002

`endif

// ---- design/lpmcs_tb_edge.v ----
// falling-edge detector on the selected base timer source
`timescale 1ns/1ps

module lpmcs_tb_edge #(
	parameter N_SRC = 8,
	parameter SEL_W = 3
) (
	input wire mclk_in,
	input wire rst_n_in,
	input wire [N_SRC-1:0] src_in,
	input wire [SEL_W-1:0] sel_in,
	output wire fall_out
);

	reg prev_reg;
	reg fall_reg;
	wire cur;

	// ------------------------------------------------------------------
	// source select and edge
	// ------------------------------------------------------------------
	assign cur = src_in[sel_in];
	assign fall_out = fall_reg;

	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			prev_reg <= 1'b0;
			fall_reg <= 1'b0;
		end else begin
			prev_reg <= cur;
			fall_reg <= prev_reg & ~cur;
		end
	end

endmodule

// ---- design/lpmcs_ctrl.v ----
// low-power halt modes and main clock switching controller
// Functional notes
// - halted: peripheral clocks gated off, base timer clock kept running
// - halted: memory, registers, status word, port latches frozen
// - halted: program counter shows entry address plus two
// - release clears halt bit, returns to previous operating mode
// - release sets base timer interrupt latch when base timer enabled
// - pin, power-on, voltage reset releases halt or low speed; warm-up
// - all enables zero: release on source falling edge, resume next
// - all enables one: release on falling edge, start interrupt service
// - release follows asynchronous source edge; halt may be short
// - watchdog interrupt just before entry blocks halt entry
// - select set: main clock becomes low/4 within 2 gear+10 low
// - oscillator enable cleared within two cycles of select: clock reset
// - switching low: main clock stopped at most ten low periods
// - select cleared: gear clock within 8 low plus 2.5 gear
// - switching fast: main clock stopped at most 2.5 gear periods
// - high osc enable with pin function zero: clock reset
// - high osc enable rewritten one: no warm-up restart
`timescale 1ns/1ps
`include "lpmcs_defs.vh"

module lpmcs_ctrl #(
	parameter N_SRC = 8,
	parameter SEL_W = 3,
	parameter PC_W = 16
) (
	input wire mclk_in,
	input wire rst_n_in,
	input wire sys_rst_req_in,
	input wire warmup_done_in,
	input wire halt_set_in,
	input wire wdt_irq_in,
	input wire [PC_W-1:0] pc_in,
	input wire master_irq_enable_in,
	input wire base_timer_irq_enable_in,
	input wire base_timer_enable_in,
	input wire [SEL_W-1:0] base_timer_clock_select_in,
	input wire [N_SRC-1:0] tb_src_in,
	input wire osc_pin_function_bit_in,
	input wire sel_wr_in,
	input wire sel_wdata_in,
	input wire high_osc_wr_in,
	input wire high_osc_wdata_in,
	input wire low_osc_wr_in,
	input wire low_osc_wdata_in,
	input wire mcycle_tick_in,
	input wire gear_tick_in,
	input wire low_tick_in,
	output wire timing_gen_halt_bit_out,
	output wire main_clock_select_out,
	output wire high_osc_enable_out,
	output wire low_osc_enable_out,
	output wire main_clk_low_out,
	output wire main_clk_stop_out,
	output wire periph_clk_en_out,
	output wire base_timer_clk_en_out,
	output wire cpu_hold_out,
	output wire [PC_W-1:0] halt_pc_out,
	output wire base_timer_latch_set_out,
	output wire irq_service_out,
	output wire resume_out,
	output wire warmup_start_out,
	output wire sys_clk_reset_out,
	output wire [2:0] mode_out
);

	reg [2:0] pwr_reg, mode_next;
	reg [3:0] clk_reg, gcnt_reg, lcnt_reg;
	reg halt_reg, sel_reg, hi_osc_reg, lo_osc_reg, low_reg, stop_reg;
	reg [1:0] lf_div_reg, win_reg;
	reg [PC_W-1:0] pc_hold_reg;
	reg latch_reg, svc_reg, resume_reg, warm_reg, sysrst_reg;
	wire tb_fall, all_on, in_win, lf_edge, is_halt;

	// ------------------------------------------------------------------
	// base timer source edge
	// ------------------------------------------------------------------
	// async source edge releases
	lpmcs_tb_edge #(
		.N_SRC(N_SRC),
		.SEL_W(SEL_W)
	) u_edge (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.src_in(tb_src_in),
		.sel_in(base_timer_clock_select_in),
		.fall_out(tb_fall)
	);

	assign all_on = master_irq_enable_in & base_timer_irq_enable_in &
		base_timer_enable_in;
	assign in_win = (win_reg != 2'h0);
	assign lf_edge = low_tick_in & (lf_div_reg == `LPMCS_LF_LAST);
	assign is_halt = (pwr_reg == `LPMCS_P_HALT);

	// ------------------------------------------------------------------
	// power state: run, halt, warm-up
	// ------------------------------------------------------------------
	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pwr_reg <= `LPMCS_P_WARM;
			halt_reg <= 1'b0;
			pc_hold_reg <= {PC_W{1'b0}};
			latch_reg <= 1'b0;
			svc_reg <= 1'b0;
			resume_reg <= 1'b0;
		end else begin
			latch_reg <= 1'b0;
			svc_reg <= 1'b0;
			resume_reg <= 1'b0;
			if (sys_rst_req_in) begin
				pwr_reg <= `LPMCS_P_WARM;
				halt_reg <= 1'b0;
			end else begin
				case (pwr_reg)
				`LPMCS_P_RUN: begin
					if (halt_set_in && !wdt_irq_in) begin
						pwr_reg <= `LPMCS_P_HALT;
						halt_reg <= 1'b1;
						pc_hold_reg <= pc_in + `LPMCS_PC_STEP;
					end
				end
				`LPMCS_P_HALT: begin
					if (tb_fall) begin
						pwr_reg <= `LPMCS_P_RUN;
						halt_reg <= 1'b0;
						latch_reg <= base_timer_enable_in;
						svc_reg <= all_on;
						resume_reg <= ~all_on;
					end
				end
				`LPMCS_P_WARM: begin
					if (warmup_done_in) begin
						pwr_reg <= `LPMCS_P_RUN;
					end
				end
				default: begin
					pwr_reg <= `LPMCS_P_WARM;
					halt_reg <= 1'b0;
				end
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// oscillator enables and select with guard window
	// ------------------------------------------------------------------
	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sel_reg <= 1'b0;
			hi_osc_reg <= 1'b1;
			lo_osc_reg <= 1'b0;
			win_reg <= 2'h0;
			warm_reg <= 1'b0;
			sysrst_reg <= 1'b0;
		end else begin
			warm_reg <= 1'b0;
			sysrst_reg <= 1'b0;
			if (sys_rst_req_in) begin
				sel_reg <= 1'b0;
				hi_osc_reg <= 1'b1;
				lo_osc_reg <= 1'b0;
				win_reg <= 2'h0;
			end else begin
				if (sel_wr_in && (sel_wdata_in != sel_reg)) begin
					sel_reg <= sel_wdata_in;
					win_reg <= `LPMCS_WIN_MC;
				end else if (in_win && mcycle_tick_in) begin
					win_reg <= win_reg - 2'h1;
				end
				if (high_osc_wr_in) begin
					if (high_osc_wdata_in && !osc_pin_function_bit_in) begin
						sysrst_reg <= 1'b1;
					end else if (!high_osc_wdata_in && in_win) begin
						sysrst_reg <= 1'b1;
					end else begin
						hi_osc_reg <= high_osc_wdata_in;
						warm_reg <= high_osc_wdata_in & ~hi_osc_reg;
					end
				end
				if (low_osc_wr_in) begin
					if (!low_osc_wdata_in && in_win) begin
						sysrst_reg <= 1'b1;
					end else begin
						lo_osc_reg <= low_osc_wdata_in;
						if (low_osc_wdata_in && !lo_osc_reg) begin
							warm_reg <= 1'b1;
						end
					end
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// main clock switch
	// ------------------------------------------------------------------
	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			clk_reg <= `LPMCS_C_FAST;
			low_reg <= 1'b0;
			stop_reg <= 1'b0;
			gcnt_reg <= 4'h0;
			lcnt_reg <= 4'h0;
			lf_div_reg <= 2'h0;
		end else begin
			if (low_tick_in) begin
				lf_div_reg <= lf_div_reg + 2'h1;
			end
			if (sys_rst_req_in) begin
				clk_reg <= `LPMCS_C_FAST;
				low_reg <= 1'b0;
				stop_reg <= 1'b0;
			end else begin
				case (clk_reg)
				`LPMCS_C_FAST: begin
					gcnt_reg <= 4'h0;
					lcnt_reg <= 4'h0;
					if (sel_reg) begin
						clk_reg <= `LPMCS_C_TO_LOW;
					end
				end
				`LPMCS_C_TO_LOW: begin
					if (!stop_reg) begin
						if (gear_tick_in) begin
							gcnt_reg <= gcnt_reg + 4'h1;
							if (gcnt_reg + 4'h1 == `LPMCS_TO_LOW_GEAR) begin
								stop_reg <= 1'b1;
							end
						end
					end else if (low_tick_in) begin
						lcnt_reg <= lcnt_reg + 4'h1;
						// stop bounded to ten low periods
						if (lf_edge ||
							lcnt_reg + 4'h1 == `LPMCS_TO_LOW_LF) begin
							low_reg <= 1'b1;
							stop_reg <= 1'b0;
							clk_reg <= `LPMCS_C_LOW;
						end
					end
				end
				`LPMCS_C_LOW: begin
					gcnt_reg <= 4'h0;
					lcnt_reg <= 4'h0;
					if (!sel_reg) begin
						clk_reg <= `LPMCS_C_TO_FAST;
					end
				end
				`LPMCS_C_TO_FAST: begin
					if (!stop_reg) begin
						if (low_tick_in) begin
							lcnt_reg <= lcnt_reg + 4'h1;
							if (lf_edge ||
								lcnt_reg + 4'h1 == `LPMCS_TO_FAST_LF) begin
								stop_reg <= 1'b1;
							end
						end
					end else if (gear_tick_in) begin
						gcnt_reg <= gcnt_reg + 4'h1;
						if (gcnt_reg + 4'h1 == `LPMCS_TO_FAST_GEAR) begin
							low_reg <= 1'b0;
							stop_reg <= 1'b0;
							clk_reg <= `LPMCS_C_FAST;
						end
					end
				end
				default: begin
					clk_reg <= `LPMCS_C_FAST;
					low_reg <= 1'b0;
					stop_reg <= 1'b0;
				end
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// mode report
	// ------------------------------------------------------------------
	always @* begin
		mode_next = `LPMCS_MODE_SINGLE;
		if (pwr_reg == `LPMCS_P_WARM) begin
			mode_next = `LPMCS_MODE_WARM;
		end else if (is_halt) begin
			mode_next = low_reg ? `LPMCS_MODE_SLEEP : `LPMCS_MODE_IDLE;
		end else if (low_reg) begin
			mode_next = `LPMCS_MODE_LOW;
		end else if (lo_osc_reg) begin
			mode_next = `LPMCS_MODE_DUAL;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	// gate peripherals, keep base timer
	assign periph_clk_en_out = (pwr_reg == `LPMCS_P_RUN) & ~stop_reg;
	assign base_timer_clk_en_out = 1'b1;
	assign cpu_hold_out = (pwr_reg != `LPMCS_P_RUN) | stop_reg;
	assign halt_pc_out = pc_hold_reg;
	assign timing_gen_halt_bit_out = halt_reg;
	assign main_clock_select_out = sel_reg;
	assign high_osc_enable_out = hi_osc_reg;
	assign low_osc_enable_out = lo_osc_reg;
	assign main_clk_low_out = low_reg;
	assign main_clk_stop_out = stop_reg;
	assign base_timer_latch_set_out = latch_reg;
	assign irq_service_out = svc_reg;
	assign resume_out = resume_reg;
	assign warmup_start_out = warm_reg;
	assign sys_clk_reset_out = sysrst_reg;
	assign mode_out = mode_next;

endmodule

// ---- bench/lpmcs_ctrl_props.sv ----
// port assertions for the halt and clock switch controller
`timescale 1ns/1ps
// ------------------------------------------------
// checker
// ------------------------------------------------
module lpmcs_ctrl_props #(
	parameter PC_W = 16
) (
	input wire mclk_in,
	input wire rst_n_in,
	input wire sys_rst_req_in,
	input wire halt_set_in,
	input wire wdt_irq_in,
	input wire [PC_W-1:0] pc_in,
	input wire master_irq_enable_in,
	input wire base_timer_irq_enable_in,
	input wire base_timer_enable_in,
	input wire osc_pin_function_bit_in,
	input wire high_osc_wr_in,
	input wire high_osc_wdata_in,
	input wire timing_gen_halt_bit_out,
	input wire main_clock_select_out,
	input wire high_osc_enable_out,
	input wire main_clk_low_out,
	input wire main_clk_stop_out,
	input wire periph_clk_en_out,
	input wire base_timer_clk_en_out,
	input wire cpu_hold_out,
	input wire [PC_W-1:0] halt_pc_out,
	input wire base_timer_latch_set_out,
	input wire irq_service_out,
	input wire resume_out,
	input wire warmup_start_out,
	input wire sys_clk_reset_out,
	input wire [2:0] mode_out
);
	reg [6:0] stop_cnt_reg;
	wire all_en;
	assign all_en = master_irq_enable_in & base_timer_irq_enable_in &
		base_timer_enable_in;
	// cycles the main clock has stood so far
	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			stop_cnt_reg <= 7'h00;
		else if (main_clk_stop_out)
			stop_cnt_reg <= stop_cnt_reg + 7'h01;
		else
			stop_cnt_reg <= 7'h00;
	end
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);
	sequence s_rel;
		$fell(timing_gen_halt_bit_out) && !$past(sys_rst_req_in);
	endsequence
	sequence s_sel_chg;
		$changed(main_clock_select_out) && !$past(sys_rst_req_in);
	endsequence
	property p_gate;
		timing_gen_halt_bit_out |-> !periph_clk_en_out && cpu_hold_out &&
			base_timer_clk_en_out;
	endproperty
	property p_pc;
		$rose(timing_gen_halt_bit_out) |-> halt_pc_out == $past(pc_in) +
			16'h0002;
	endproperty
	property p_freeze;
		timing_gen_halt_bit_out && $past(timing_gen_halt_bit_out) |->
			$stable(halt_pc_out);
	endproperty
	property p_rel;
		s_rel |-> resume_out != irq_service_out &&
			base_timer_latch_set_out == $past(base_timer_enable_in);
	endproperty
	property p_kind;
		s_rel |-> irq_service_out == $past(all_en);
	endproperty
	property p_wdt;
		halt_set_in && wdt_irq_in && !timing_gen_halt_bit_out |=>
			!timing_gen_halt_bit_out;
	endproperty
	property p_sysrst;
		sys_rst_req_in |=> mode_out == 3'h5 && !timing_gen_halt_bit_out &&
			!main_clock_select_out;
	endproperty
	property p_low;
		$rose(main_clock_select_out) |-> ##[1:88] main_clk_low_out;
	endproperty
	property p_fast;
		$fell(main_clock_select_out) |-> ##[1:72] !main_clk_low_out;
	endproperty
	property p_stop;
		main_clk_stop_out |-> stop_cnt_reg < (main_clk_low_out ? 7'h06 :
			7'h52);
	endproperty
	property p_guard;
		s_sel_chg ##1 (high_osc_wr_in && !high_osc_wdata_in &&
			!sys_rst_req_in) |=>
			sys_clk_reset_out && $stable(high_osc_enable_out);
	endproperty
	property p_pin;
		high_osc_wr_in && high_osc_wdata_in && !osc_pin_function_bit_in &&
			!sys_rst_req_in |=> sys_clk_reset_out;
	endproperty
	property p_rewr;
		high_osc_wr_in && high_osc_wdata_in && high_osc_enable_out |=>
			!warmup_start_out;
	endproperty
	a_gate: assert property (p_gate) else $error("halt gating wrong");
	a_pc: assert property (p_pc) else $error("halt address wrong");
	a_freeze: assert property (p_freeze) else $error("address moved");
	a_rel: assert property (p_rel) else $error("release pulses wrong");
	a_kind: assert property (p_kind) else $error("release kind wrong");
	a_wdt: assert property (p_wdt) else $error("halt not blocked");
	a_sysrst: assert property (p_sysrst) else $error("reset wrong");
	a_low: assert property (p_low) else $error("low switch late");
	a_fast: assert property (p_fast) else $error("fast switch late");
	a_stop: assert property (p_stop) else $error("clock stop long");
	a_guard: assert property (p_guard) else $error("no guard reset");
	a_pin: assert property (p_pin) else $error("no pin reset");
	a_rewr: assert property (p_rewr) else $error("warm-up rerun");
endmodule

bind lpmcs_ctrl lpmcs_ctrl_props #(
	.PC_W(PC_W)
) u_props (
	.mclk_in(mclk_in),
	.rst_n_in(rst_n_in),
	.sys_rst_req_in(sys_rst_req_in),
	.halt_set_in(halt_set_in),
	.wdt_irq_in(wdt_irq_in),
	.pc_in(pc_in),
	.master_irq_enable_in(master_irq_enable_in),
	.base_timer_irq_enable_in(base_timer_irq_enable_in),
	.base_timer_enable_in(base_timer_enable_in),
	.osc_pin_function_bit_in(osc_pin_function_bit_in),
	.high_osc_wr_in(high_osc_wr_in),
	.high_osc_wdata_in(high_osc_wdata_in),
	.timing_gen_halt_bit_out(timing_gen_halt_bit_out),
	.main_clock_select_out(main_clock_select_out),
	.high_osc_enable_out(high_osc_enable_out),
	.main_clk_low_out(main_clk_low_out),
	.main_clk_stop_out(main_clk_stop_out),
	.periph_clk_en_out(periph_clk_en_out),
	.base_timer_clk_en_out(base_timer_clk_en_out),
	.cpu_hold_out(cpu_hold_out),
	.halt_pc_out(halt_pc_out),
	.base_timer_latch_set_out(base_timer_latch_set_out),
	.irq_service_out(irq_service_out),
	.resume_out(resume_out),
	.warmup_start_out(warmup_start_out),
	.sys_clk_reset_out(sys_clk_reset_out),
	.mode_out(mode_out)
);

// ---- bench/lpmcs_fw_model.sv ----
// firmware model issuing control writes to the controller
`timescale 1ns/1ps
// ------------------------------------------------
// write strobes
// ------------------------------------------------
module lpmcs_fw_model (
	input wire mclk_in,
	output reg halt_set_out,
	output reg sel_wr_out,
	output reg hi_wr_out,
	output reg lo_wr_out,
	output reg wdata_out
);
	initial begin
		{halt_set_out, sel_wr_out, hi_wr_out, lo_wr_out} = 4'h0;
		wdata_out = 1'b0;
	end
	// 0 halt, 1 select, 2 high osc, 3 low osc
	// halt written alone
	task strobe(input integer which, input reg v);
		begin
			@(posedge mclk_in);
			#1;
			wdata_out = v;
			halt_set_out = (which == 0);
			sel_wr_out = (which == 1);
			hi_wr_out = (which == 2);
			lo_wr_out = (which == 3);
			@(posedge mclk_in);
			#1;
			{halt_set_out, sel_wr_out, hi_wr_out, lo_wr_out} = 4'h0;
		end
	endtask
	task settle(input integer n);
		repeat (4 * n + 4) @(posedge mclk_in);
	endtask
endmodule

// ---- bench/test_low_power_mode_clock_switch.sv ----
// self-checking bench for the halt and clock switch controller
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
	n_mismatch++; $display("Error at %0t: got %h expected %h", $time, \
	(a), (b)); end end
// ------------------------------------------------
// bench top
// ------------------------------------------------
module test_low_power_mode_clock_switch;
	reg mclk_in = 1'b0;
	reg rst_n_in = 1'b0;
	reg sys_rst = 1'b0, warm_done = 1'b0, wdt = 1'b0, pin = 1'b0;
	reg [2:0] en = 3'h0, tsel = 3'h1;
	reg [15:0] pc = 16'h0000;
	reg [9:0] cnt = 10'h000;
	reg seen_rst, seen_warm;
	integer n_mismatch = 0, total_checks = 0, n;
	integer stop_cyc = 0, mark = 0;
	wire halt_set, sel_wr, hi_wr, lo_wr, wdata, halt, sel, hi_en, lo_en;
	wire low, stop, pen, bten, hold, latch, irq, res, wst, crst;
	wire [15:0] hpc;
	wire [2:0] mode;
	wire [2:0] watch = {mode == 3'h5, low, halt};
	always #25 mclk_in = ~mclk_in;
	always @(posedge mclk_in) cnt <= #1 cnt + 10'h001;
	// cycles the main clock has stood stopped
	always @(posedge mclk_in) if (stop === 1'b1) stop_cyc <= stop_cyc + 1;
	lpmcs_fw_model u_fw (.mclk_in(mclk_in), .halt_set_out(halt_set),
		.sel_wr_out(sel_wr), .hi_wr_out(hi_wr), .lo_wr_out(lo_wr),
		.wdata_out(wdata));
	lpmcs_ctrl DUT (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
		.sys_rst_req_in(sys_rst), .warmup_done_in(warm_done),
		.halt_set_in(halt_set), .wdt_irq_in(wdt), .pc_in(pc),
		.master_irq_enable_in(en[2]), .base_timer_irq_enable_in(en[1]),
		.base_timer_enable_in(en[0]), .base_timer_clock_select_in(tsel),
		.tb_src_in(cnt[9:2]), .osc_pin_function_bit_in(pin),
		.sel_wr_in(sel_wr), .sel_wdata_in(wdata), .high_osc_wr_in(hi_wr),
		.high_osc_wdata_in(wdata), .low_osc_wr_in(lo_wr),
		.low_osc_wdata_in(wdata), .mcycle_tick_in(&cnt[1:0]),
		.gear_tick_in(cnt[0]), .low_tick_in(&cnt[2:0]),
		.timing_gen_halt_bit_out(halt), .main_clock_select_out(sel),
		.high_osc_enable_out(hi_en), .low_osc_enable_out(lo_en),
		.main_clk_low_out(low), .main_clk_stop_out(stop),
		.periph_clk_en_out(pen), .base_timer_clk_en_out(bten),
		.cpu_hold_out(hold), .halt_pc_out(hpc),
		.base_timer_latch_set_out(latch), .irq_service_out(irq),
		.resume_out(res), .warmup_start_out(wst),
		.sys_clk_reset_out(crst), .mode_out(mode));
	task finish_test;
		begin
			$display("checks %0d mismatches %0d", total_checks, n_mismatch);
			if (n_mismatch == 0 && total_checks > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask
	// one-cycle pulses seen over two cycles
	task grab;
		begin
			seen_rst = 1'b0;
			seen_warm = 1'b0;
			repeat (2) begin
				seen_rst = seen_rst | crst;
				seen_warm = seen_warm | wst;
				@(posedge mclk_in);
				#1;
			end
		end
	endtask
	task wait_for(input integer which, input reg v);
		begin
			n = 0;
			while (watch[which] !== v && n < 120) begin
				@(posedge mclk_in);
				#1;
				n = n + 1;
			end
			if (n >= 120) begin
				n_mismatch++;
				$display("Error at %0t: got %h expected %h", $time,
					watch[which], v);
				finish_test;
			end
		end
	endtask
	task halt_cycle(input [2:0] e, input [15:0] a, input [2:0] m,
		input [2:0] back);
		begin
			en = e;
			pc = a;
			u_fw.strobe(0, 1'b1);
			`CHK({halt, mode}, {1'b1, m})
			`CHK(hpc, a + 16'h0002)
			`CHK({pen, bten, hold}, 3'h3)
			pc = ~a;
			wait_for(0, 1'b0);
			`CHK({irq, res}, (&e) ? 2'h2 : 2'h1)
			`CHK({latch, mode}, {e[0], back})
			`CHK(hpc, a + 16'h0002)
		end
	endtask
	initial begin
		repeat (12) @(posedge mclk_in);
		#1;
		rst_n_in = 1'b1;
		`CHK(mode, 3'h5)
		warm_done = 1'b1;
		wait_for(2, 1'b0);
		`CHK(mode, 3'h0)
		halt_cycle(3'h0, 16'hFFFF, 3'h3, 3'h0);
		halt_cycle(3'h7, 16'h1234, 3'h3, 3'h0);
		halt_cycle(3'h5, 16'h0FFE, 3'h3, 3'h0);
		wdt = 1'b1;
		u_fw.strobe(0, 1'b1);
		`CHK(halt, 1'b0)
		wdt = 1'b0;
		warm_done = 1'b0;
		u_fw.strobe(0, 1'b1);
		sys_rst = 1'b1;
		@(posedge mclk_in);
		#1;
		sys_rst = 1'b0;
		`CHK({halt, mode}, 4'h5)
		warm_done = 1'b1;
		wait_for(2, 1'b0);
		u_fw.strobe(3, 1'b1);
		grab;
		`CHK({seen_warm, lo_en, mode}, 5'h19)
		mark = stop_cyc;
		u_fw.strobe(1, 1'b1);
		`CHK(sel, 1'b1)
		u_fw.strobe(2, 1'b0);
		grab;
		`CHK({seen_rst, hi_en}, 2'h3)
		wait_for(1, 1'b1);
		`CHK(n + 4 <= 88, 1'b1)
		`CHK({stop, sel}, 2'h1)
		`CHK(stop_cyc - mark >= 1 && stop_cyc - mark <= 80, 1'b1)
		u_fw.settle(2);
		u_fw.strobe(2, 1'b0);
		grab;
		`CHK({seen_rst, hi_en, mode}, 5'h02)
		halt_cycle(3'h7, 16'h2000, 3'h4, 3'h2);
		u_fw.strobe(2, 1'b1);
		grab;
		`CHK({seen_rst, hi_en}, 2'h2)
		pin = 1'b1;
		u_fw.strobe(2, 1'b1);
		grab;
		`CHK({seen_warm, hi_en}, 2'h3)
		u_fw.strobe(2, 1'b1);
		grab;
		`CHK({seen_warm, seen_rst}, 2'h0)
		u_fw.settle(4);
		mark = stop_cyc;
		u_fw.strobe(1, 1'b0);
		`CHK(sel, 1'b0)
		u_fw.strobe(3, 1'b0);
		grab;
		`CHK({seen_rst, lo_en}, 2'h3)
		wait_for(1, 1'b0);
		`CHK(n + 5 <= 71, 1'b1)
		`CHK({stop, sel}, 2'h0)
		`CHK(stop_cyc - mark >= 1 && stop_cyc - mark <= 5, 1'b1)
		u_fw.settle(2);
		u_fw.strobe(3, 1'b0);
		grab;
		`CHK({seen_rst, lo_en, mode}, 5'h00)
		finish_test;
	end
endmodule
